// ---- inc/iae_pkg.sv ----
/*
 Constants, register map and carrier types for the interrupt accept block.
 Assumes a 40 MHz system clock and a CPU sequencer on the same clock.
*/
package iae_pkg;
	localparam int CLK_KHZ = 40000;
	// One instruction cycle, and the least accepted pin pulse, in ns
	localparam int INSTR_NS = 1780;
	localparam int FILT_NS = 100;
	// Longest time rounds down, least time rounds up
	localparam int INSTR_CYC = (INSTR_NS * CLK_KHZ) / 1000000;
	localparam int FILT_CYC = (FILT_NS * CLK_KHZ + 999999) / 1000000;
	localparam logic [6:0] INSTR_LAST = 7'(INSTR_CYC - 1);
	localparam logic [2:0] FILT_LAST = 3'(FILT_CYC - 1);
	localparam logic [2:0] INIT_LAST = 3'h3;

	localparam int NSRC = 12;
	localparam int NPIN = 6;
	localparam int ISK_DEPTH = 4;
	localparam int ASK_DEPTH = 8;
	localparam int PC_W = 14;

	// Wishbone byte addresses
	localparam logic [7:0] ADR_PEND = 8'h00;
	localparam logic [7:0] ADR_ENAB = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_EDGE_HI = 8'h0c;
	localparam logic [7:0] EDGE_IDX = 8'h1f;
	localparam logic [7:0] ADR_EDGE = {EDGE_IDX[5:0], 2'b00};

	localparam logic [2:0] EDGE_RST = 3'h0;
	localparam logic [1:0] EDGE_HI_RST = 2'h0;
	localparam logic [11:0] PEND_RST = 12'h000;
	localparam logic [11:0] ENAB_RST = 12'h000;
	localparam logic [2:0] SP_RST = 3'h0;
	localparam logic [2:0] LVL_RST = 3'h0;
	localparam logic [2:0] LVL_MAX = 3'h4;
	// Vector of the top-ranked source; each lower rank is one below
	localparam logic [PC_W-1:0] VEC_TOP = 14'h000c;

	// Status register field positions
	localparam int STAT_GIE_BIT = 0;
	localparam int STAT_LVL_LSB = 4;
	localparam int STAT_SP_LSB = 8;

	// System register load masks {wr, bank, ix, rp, psw}
	localparam logic [4:0] LOAD_ACCEPT = 5'h0f;
	localparam logic [4:0] LOAD_IRQ_RETURN_INSTR = 5'h1f;
	localparam logic [4:0] LOAD_RET = 5'h13;

	typedef struct packed {
		logic instr_end;
		logic ei;
		logic di;
		logic irq_return_instr;
		logic ret;
		logic hold;
	} iae_cpu_evt_t;

	typedef struct packed {
		logic [3:0] wr;
		logic [3:0] bank;
		logic [11:0] ix;
		logic [7:0] rp;
		logic [3:0] psw;
	} iae_sysreg_t;
endpackage

// ---- rtl/iae_irq_accept.sv ----
/*
 Interrupt request flags, priority chain, interrupt cycle, return handling
 and external pin edge selection, with a classic Wishbone register slave.
 Assumes the CPU sequencer, timers and serial units share sys_clk and that
 the CPU stalls while irq_cycle is high.
*/
// Implementation choice: register access over Wishbone.
// Operation
// - A source event sets that source's pending flag.
// - Take only when pending, source enable and global enable are all one.
// - Rank: CE fall, pins 0 to 4, timers 0 to 3, serial 2, 3.
// - An asserting source stops the accept chain for lower ranks.
// - A cleared source enable masks the source regardless of rank.
// - Enable instruction sets global enable late; no take at its own end.
// - Disable instruction clears global enable during its own execution.
// - Table read first cycle or skip defers acceptance to the next boundary.
// - Acceptance clears global enable and the taken pending flag.
// - Acceptance decrements stack pointer and stores the PC there.
// - Saved PC is the next address to execute, given by the CPU.
// - Acceptance pushes all system registers except address register.
// - Vector loads into PC; interrupt cycle lasts one instruction cycle.
// - Interrupt return restores PC and system registers together, then increments SP.
// - Subroutine returns restore alike but leave bank and index alone.
// - CE falling edge and per-pin selectable edge raise external requests.
// - Pulses shorter than 100 ns on pins are ignored.
// - Edge select holds pins 0 to 2 in bits 0 to 2; bit 3 reads zero.
// - Edge select clears on power-on and watchdog reset, kept on CE reset.
// - Interrupt stack holds four sets; deeper pushes drop the oldest.
// - After the push, saved registers except window clear to zero.
// - Changing edge select raises a request if the level matches new edge.
`timescale 1ns/1ps
module iae_irq_accept (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wdt_sp_reset,
	input wire logic ce_reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ce_pin,
	input wire logic [4:0] ext_irq_pin,
	input wire logic [5:0] periph_irq,
	input wire iae_pkg::iae_cpu_evt_t cpu_evt,
	input wire logic [iae_pkg::PC_W-1:0] pc_next,
	input wire iae_pkg::iae_sysreg_t sys_cur,
	output logic irq_cycle,
	output logic pc_load,
	output logic [iae_pkg::PC_W-1:0] pc_value,
	output logic [4:0] sys_load,
	output iae_pkg::iae_sysreg_t sys_value
);

	function automatic logic [3:0] onehot_idx(input logic [iae_pkg::NSRC-1:0] oh);
		logic [3:0] r;
		r = 4'h0;
		for (int k = 0; k < iae_pkg::NSRC; k++) begin
			if (oh[k]) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction

	// Pin conditioning
	logic [5:0] pin_raw;
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic [5:0] filt_w;
	logic [5:0] eff_w;
	logic [5:0] eff_prev_reg;
	logic [5:0] pin_evt;
	logic [5:0] sel_all;
	logic [2:0] init_cnt_reg;
	logic init_done;

	// Flags and control
	logic [11:0] pend_reg;
	logic [11:0] pend_next;
	logic [11:0] enab_reg;
	logic [11:0] enab_next;
	logic [2:0] edge_reg;
	logic [1:0] edge_hi_reg;
	logic gie_reg;
	logic gie_next;
	logic any_reset;

	// Acceptance
	logic [11:0] src_evt;
	logic [11:0] req;
	logic [12:0] chain;
	logic [11:0] grant;
	logic boundary;
	logic take_ok;
	logic accept;
	logic do_irq_return_instr;
	logic do_ret;
	logic do_pop;
	logic [6:0] busy_cnt_reg;
	logic irq_cycle_reg;
	logic [iae_pkg::PC_W-1:0] vec_w;

	// Stacks
	logic [iae_pkg::PC_W-1:0] ask_mem [iae_pkg::ASK_DEPTH];
	logic [2:0] sp_reg;
	logic [2:0] sp_dec;
	iae_pkg::iae_sysreg_t isk_mem [iae_pkg::ISK_DEPTH];
	logic [2:0] lvl_reg;
	iae_pkg::iae_sysreg_t sys_cleared;

	// Outputs
	logic pc_load_reg;
	logic [iae_pkg::PC_W-1:0] pc_value_reg;
	logic [4:0] sys_load_reg;
	iae_pkg::iae_sysreg_t sys_value_reg;

	// Bus
	logic ack_reg;
	logic [31:0] dat_reg;
	logic wb_hit;
	logic wr_en;
	logic [15:0] wmask;
	logic [15:0] wdat_m;
	logic [11:0] pend_wclr;
	logic [31:0] rd_word;
	logic [31:0] stat_word;

	assign pin_raw = {ext_irq_pin, ce_pin};
	assign init_done = (init_cnt_reg == iae_pkg::INIT_LAST);
	assign any_reset = wdt_sp_reset | ce_reset;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
			init_cnt_reg <= 3'h0;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			if (!init_done) begin
				init_cnt_reg <= init_cnt_reg + 3'h1;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < iae_pkg::NPIN; gi++) begin : g_filt
			logic filt_reg;
			logic [2:0] fcnt_reg;
			assign filt_w[gi] = filt_reg;
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					filt_reg <= 1'b0;
					fcnt_reg <= 3'h0;
				end else if (!init_done) begin
					filt_reg <= sync2_reg[gi];
					fcnt_reg <= 3'h0;
				end else if (sync2_reg[gi] != filt_reg) begin
					if (fcnt_reg == iae_pkg::FILT_LAST) begin
						filt_reg <= sync2_reg[gi];
						fcnt_reg <= 3'h0;
					end else begin
						fcnt_reg <= fcnt_reg + 3'h1;
					end
				end else begin
					fcnt_reg <= 3'h0;
				end
			end
		end
	endgenerate

	// CE is fixed to falling; pins use their select bit
	assign sel_all = {edge_hi_reg, edge_reg, 1'b1};
	// select change flips the effective level, seen as an edge
	assign eff_w = filt_w ^ sel_all;
	assign pin_evt = eff_w & ~eff_prev_reg & {6{init_done}};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			eff_prev_reg <= 6'h00;
		end else begin
			eff_prev_reg <= eff_w;
		end
	end

	assign src_evt = {periph_irq, pin_evt};

	// a source requests only when also enabled
	assign req = pend_reg & enab_reg;

	assign boundary = cpu_evt.instr_end & ~irq_cycle_reg;
	// table read first cycle or skip holds acceptance off
	// no take at the disabling boundary
	// old flip-flop value keeps the enabling boundary out
	assign take_ok = boundary & gie_reg & ~cpu_evt.hold & ~cpu_evt.di
		& ~cpu_evt.irq_return_instr & ~cpu_evt.ret;

	// accept chain stops at the first asserting source
	assign chain[0] = take_ok;
	generate
		for (gi = 0; gi < iae_pkg::NSRC; gi++) begin : g_chain
			assign grant[gi] = chain[gi] & req[gi];
			assign chain[gi+1] = chain[gi] & ~req[gi];
		end
	endgenerate
	assign accept = |grant;
	assign vec_w = iae_pkg::VEC_TOP - {10'h000, onehot_idx(grant)};

	assign do_irq_return_instr = boundary & cpu_evt.irq_return_instr;
	assign do_ret = boundary & cpu_evt.ret;
	assign do_pop = do_irq_return_instr | do_ret;

	// Bus decode
	assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr_en = wb_hit & wb_we_i;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat_m = wb_dat_i[15:0] & wmask;
	assign pend_wclr = (wr_en && wb_adr_i == iae_pkg::ADR_PEND) ? wdat_m[11:0] : 12'h000;

	// an event in the clearing cycle wins
	assign pend_next = (pend_reg & ~(pend_wclr | grant)) | src_evt;
	assign enab_next = (wr_en && wb_adr_i == iae_pkg::ADR_ENAB)
		? ((enab_reg & ~wmask[11:0]) | wdat_m[11:0]) : enab_reg;

	always_comb begin
		gie_next = gie_reg;
		if (accept) begin
			gie_next = 1'b0;
		end else if (boundary && cpu_evt.di) begin
			// cleared by the disabling instruction itself
			gie_next = 1'b0;
		end else if (boundary && cpu_evt.ei) begin
			// visible only from the following instruction
			gie_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_reg <= iae_pkg::PEND_RST;
			enab_reg <= iae_pkg::ENAB_RST;
			gie_reg <= 1'b0;
		end else if (any_reset) begin
			pend_reg <= iae_pkg::PEND_RST;
			enab_reg <= iae_pkg::ENAB_RST;
			gie_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			enab_reg <= enab_next;
			gie_reg <= gie_next;
		end
	end

	// edge select, kept over CE reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			edge_reg <= iae_pkg::EDGE_RST;
			edge_hi_reg <= iae_pkg::EDGE_HI_RST;
		end else if (wdt_sp_reset) begin
			edge_reg <= iae_pkg::EDGE_RST;
			edge_hi_reg <= iae_pkg::EDGE_HI_RST;
		end else if (wr_en && wb_sel_i[0]) begin
			if (wb_adr_i == iae_pkg::ADR_EDGE) begin
				edge_reg <= wb_dat_i[2:0];
			end
			if (wb_adr_i == iae_pkg::ADR_EDGE_HI) begin
				edge_hi_reg <= wb_dat_i[1:0];
			end
		end
	end

	// interrupt cycle of one instruction time
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_cycle_reg <= 1'b0;
			busy_cnt_reg <= 7'h00;
		end else if (accept) begin
			irq_cycle_reg <= 1'b1;
			busy_cnt_reg <= iae_pkg::INSTR_LAST;
		end else if (busy_cnt_reg != 7'h00) begin
			busy_cnt_reg <= busy_cnt_reg - 7'h01;
		end else begin
			irq_cycle_reg <= 1'b0;
		end
	end

	// decrement then store at the new pointer
	assign sp_dec = sp_reg - 3'h1;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sp_reg <= iae_pkg::SP_RST;
		end else if (any_reset) begin
			sp_reg <= iae_pkg::SP_RST;
		end else if (accept) begin
			sp_reg <= sp_dec;
		end else if (do_pop) begin
			// pointer moves up after the PC is read
			sp_reg <= sp_reg + 3'h1;
		end
	end

	// Address stack has no reset; contents are don't-care until written
	always_ff @(posedge sys_clk) begin
		if (accept) begin
			// CPU supplies the next address to execute
			ask_mem[sp_dec] <= pc_next;
		end
	end

	// shift stack; the oldest set falls off the bottom
	generate
		for (gi = 0; gi < iae_pkg::ISK_DEPTH; gi++) begin : g_isk
			always_ff @(posedge sys_clk) begin
				if (accept) begin
					// every system register but the address register
					isk_mem[gi] <= (gi == 0) ? sys_cur : isk_mem[(gi == 0) ? 0 : gi - 1];
				end else if (do_pop && gi < iae_pkg::ISK_DEPTH - 1) begin
					isk_mem[gi] <= isk_mem[(gi < iae_pkg::ISK_DEPTH - 1) ? gi + 1 : gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lvl_reg <= iae_pkg::LVL_RST;
		end else if (any_reset) begin
			lvl_reg <= iae_pkg::LVL_RST;
		end else if (accept && lvl_reg != iae_pkg::LVL_MAX) begin
			lvl_reg <= lvl_reg + 3'h1;
		end else if (do_pop && lvl_reg != 3'h0) begin
			lvl_reg <= lvl_reg - 3'h1;
		end
	end

	assign sys_cleared = '{wr: sys_cur.wr, bank: 4'h0, ix: 12'h000, rp: 8'h00, psw: 4'h0};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_load_reg <= 1'b0;
			pc_value_reg <= '0;
			sys_load_reg <= 5'h00;
			sys_value_reg <= '0;
		end else if (accept) begin
			// branch to the taken source's vector
			pc_load_reg <= 1'b1;
			pc_value_reg <= vec_w;
			// cleared set loads back to the CPU
			sys_load_reg <= iae_pkg::LOAD_ACCEPT;
			sys_value_reg <= sys_cleared;
		end else if (do_pop) begin
			// restore PC and system registers together
			pc_load_reg <= 1'b1;
			pc_value_reg <= ask_mem[sp_reg];
			// subroutine return skips bank and index
			sys_load_reg <= do_irq_return_instr ? iae_pkg::LOAD_IRQ_RETURN_INSTR : iae_pkg::LOAD_RET;
			sys_value_reg <= isk_mem[0];
		end else begin
			pc_load_reg <= 1'b0;
			sys_load_reg <= 5'h00;
		end
	end

	// Register read mux; unmapped addresses read zero
	assign stat_word = {21'h0, sp_reg, 1'b0, lvl_reg, 3'h0, gie_reg};
	assign rd_word = (wb_adr_i == iae_pkg::ADR_PEND) ? {20'h0, pend_reg}
		: (wb_adr_i == iae_pkg::ADR_ENAB) ? {20'h0, enab_reg}
		: (wb_adr_i == iae_pkg::ADR_STAT) ? stat_word
		// bit 3 and above read zero
		: (wb_adr_i == iae_pkg::ADR_EDGE) ? {29'h0, edge_reg}
		: (wb_adr_i == iae_pkg::ADR_EDGE_HI) ? {30'h0, edge_hi_reg}
		: 32'h0;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end else begin
			ack_reg <= wb_hit;
			if (wb_hit && !wb_we_i) begin
				dat_reg <= rd_word;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign irq_cycle = irq_cycle_reg;
	assign pc_load = pc_load_reg;
	assign pc_value = pc_value_reg;
	assign sys_load = sys_load_reg;
	assign sys_value = sys_value_reg;

endmodule // iae_irq_accept

// ---- testbench/iae_irq_accept_asserts.sv ----
/*
 Checker for the interrupt accept block, bound to its top module.
 Assumes one clock, sys_clk, and the async reset reset_n.
*/
`timescale 1ns/1ps
module iae_irq_accept_asserts (
	input logic sys_clk,
	input logic reset_n,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	input iae_pkg::iae_cpu_evt_t cpu_evt,
	input iae_pkg::iae_sysreg_t sys_cur,
	input logic irq_cycle,
	input logic pc_load,
	input logic [13:0] pc_value,
	input logic [4:0] sys_load,
	input iae_pkg::iae_sysreg_t sys_value
);
	logic [6:0] irq_cnt_reg;
	logic [6:0] irq_cnt_next;
	// Counts high cycles of the interrupt cycle
	assign irq_cnt_next = irq_cycle ? irq_cnt_reg + 7'h01 : 7'h00;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			irq_cnt_reg <= 7'h00;
		else
			irq_cnt_reg <= irq_cnt_next;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_boundary;
		cpu_evt.instr_end && !irq_cycle;
	endsequence
	sequence s_take;
		cpu_evt.instr_end ##1 $rose(irq_cycle);
	endsequence
	AST_TAKE_AT_END: assert property ($rose(irq_cycle) |-> $past(cpu_evt.instr_end) &&
		!$past(cpu_evt.hold || cpu_evt.di || cpu_evt.irq_return_instr || cpu_evt.ret))
		else $error("interrupt taken off a plain boundary");
	AST_EI_LATE: assert property (cpu_evt.instr_end && cpu_evt.ei && !irq_cycle |=>
		!irq_cycle) else $error("taken at enable instruction end");
	AST_DI_NOW: assert property (s_boundary ##0 cpu_evt.di |=> !irq_cycle)
		else $error("taken at disable instruction end");
	AST_VECTOR: assert property (s_take |-> pc_load && pc_value <= iae_pkg::VEC_TOP &&
		pc_value >= iae_pkg::VEC_TOP - 14'h00b) else $error("vector out of range");
	AST_PUSH_MASK: assert property ($rose(irq_cycle) |-> sys_load == iae_pkg::LOAD_ACCEPT)
		else $error("wrong push mask");
	AST_CLEAR_SAVED: assert property ($rose(irq_cycle) |-> sys_value.wr == $past(sys_cur.wr) &&
		{sys_value.bank, sys_value.ix, sys_value.rp, sys_value.psw} == 28'h0)
		else $error("saved registers not cleared");
	AST_CYCLE_LEN: assert property ($fell(irq_cycle) |->
		irq_cnt_reg == iae_pkg::INSTR_LAST + 7'h01) else $error("interrupt cycle length");
	AST_CYCLE_MAX: assert property (irq_cycle |-> irq_cnt_reg <= iae_pkg::INSTR_LAST)
		else $error("interrupt cycle too long");
	AST_IRQ_RETURN_INSTR: assert property (s_boundary ##0 cpu_evt.irq_return_instr |=>
		pc_load && sys_load == iae_pkg::LOAD_IRQ_RETURN_INSTR) else $error("interrupt return restore");
	AST_RET: assert property (s_boundary ##0 cpu_evt.ret && !cpu_evt.irq_return_instr |=>
		pc_load && sys_load == iae_pkg::LOAD_RET) else $error("subroutine return restore");
	AST_EDGE_BIT3: assert property (wb_ack_o && !wb_we_i && wb_adr_i == iae_pkg::ADR_EDGE |->
		wb_dat_o[31:3] == 29'h0) else $error("edge select upper bits set");
endmodule // iae_irq_accept_asserts
bind iae_irq_accept iae_irq_accept_asserts i_chk (.sys_clk, .reset_n, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .cpu_evt, .sys_cur, .irq_cycle, .pc_load, .pc_value, .sys_load,
	.sys_value);

// ---- testbench/iae_cpu_model.sv ----
/*
 CPU sequencer model: ends an instruction every PER cycles, stalls in the
 interrupt cycle. Assumes the bench gives cmd with a one-cycle cmd_vld.
*/
`timescale 1ns/1ps
module iae_cpu_model #(
	parameter int PER = 6
) (
	input logic sys_clk,
	input logic reset_n,
	input logic [4:0] cmd,
	input logic cmd_vld,
	input logic irq_cycle,
	input logic pc_load,
	input logic [13:0] pc_value,
	input logic [4:0] sys_load,
	input iae_pkg::iae_sysreg_t sys_value,
	output iae_pkg::iae_cpu_evt_t cpu_evt,
	output logic [13:0] pc_next,
	output iae_pkg::iae_sysreg_t sys_cur
);
	int cnt;
	logic [4:0] kind;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt = 0;
			kind = 5'h00;
			cpu_evt <= '0;
			pc_next <= 14'h0000;
			sys_cur <= '0;
		end else begin
			if (cmd_vld)
				kind = cmd;
			cpu_evt <= '0;
			cnt = irq_cycle ? 0 : cnt + 1;
			if (cnt >= PER) begin
				cnt = 0;
				cpu_evt <= {1'b1, kind};
				kind = 5'h00;
				pc_next <= pc_next + 14'h0001;
				sys_cur <= iae_pkg::iae_sysreg_t'($urandom);
			end
			if (pc_load)
				pc_next <= pc_value;
			if (sys_load[4])
				sys_cur.wr <= sys_value.wr;
			if (sys_load[3])
				sys_cur.bank <= sys_value.bank;
			if (sys_load[2])
				sys_cur.ix <= sys_value.ix;
			if (sys_load[1])
				sys_cur.rp <= sys_value.rp;
			if (sys_load[0])
				sys_cur.psw <= sys_value.psw;
		end
	end
endmodule // iae_cpu_model

// ---- testbench/iae_irq_accept_bench.sv ----
/*
 Self-checking bench for the interrupt accept block.
 Assumes the CPU model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
module iae_irq_accept_bench;
	logic sys_clk, reset_n, wdt_sp_reset, ce_reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic ce_pin, irq_cycle, pc_load, cmd_vld;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd, r;
	logic [4:0] ext_irq_pin, sys_load, cmd;
	logic [5:0] periph_irq;
	logic [13:0] pc_next, pc_value, pc_saved;
	iae_pkg::iae_cpu_evt_t cpu_evt;
	iae_pkg::iae_sysreg_t sys_cur, sys_value;
	int error_cnt, n_compared, exp_pend, exp_enab, idx, i;
	iae_irq_accept i_dut (.sys_clk, .reset_n, .wdt_sp_reset, .ce_reset, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ce_pin, .ext_irq_pin,
		.periph_irq, .cpu_evt, .pc_next, .sys_cur, .irq_cycle, .pc_load, .pc_value, .sys_load,
		.sys_value);
	iae_cpu_model i_cpu (.sys_clk, .reset_n, .cmd, .cmd_vld, .irq_cycle, .pc_load, .pc_value,
		.sys_load, .sys_value, .cpu_evt, .pc_next, .sys_cur);
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic print_verdict;
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		// Hung bus ends the run as a failure
		if (i >= 20) begin
			error_cnt++;
			print_verdict();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk("register", e, rd);
	endtask
	task automatic cpu(input logic [4:0] c);
		cmd <= c;
		cmd_vld <= 1'b1;
		@(posedge sys_clk);
		cmd_vld <= 1'b0;
		for (i = 0; i < 40 && cpu_evt !== {1'b1, c}; i++)
			@(posedge sys_clk);
		chk("boundary", 1, i < 40);
		if (i >= 40) print_verdict();
	endtask
	initial begin
		r = $urandom(32'h0300);
		{reset_n, wdt_sp_reset, ce_reset, wb_cyc_i, wb_stb_i, wb_we_i, cmd_vld} = 7'h00;
		{wb_adr_i, wb_sel_i, wb_dat_i, cmd} = 49'h0;
		ce_pin = 1'b1;
		ext_irq_pin = 5'h00;
		periph_irq = 6'h00;
		error_cnt = 0;
		n_compared = 0;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wb(1'b1, 8'h40, 32'hffffffff);
		for (int k = 0; k < 8; k++)
			chk_reg(8'(k * 4), 32'h0);
		chk_reg(iae_pkg::ADR_EDGE, 32'h0);
		r = $urandom;
		wb(1'b1, iae_pkg::ADR_EDGE, r | 32'h8);
		chk_reg(iae_pkg::ADR_EDGE, {29'h0, r[2:0]});
		chk_reg(iae_pkg::ADR_PEND, {28'h0, r[2:0], 1'b0});
		ce_reset <= 1'b1;
		@(posedge sys_clk);
		ce_reset <= 1'b0;
		@(posedge sys_clk);
		chk_reg(iae_pkg::ADR_EDGE, {29'h0, r[2:0]});
		wdt_sp_reset <= 1'b1;
		@(posedge sys_clk);
		wdt_sp_reset <= 1'b0;
		@(posedge sys_clk);
		chk_reg(iae_pkg::ADR_EDGE, 32'h0);
		ext_irq_pin <= 5'h04;
		repeat (2) @(posedge sys_clk);
		ext_irq_pin <= 5'h00;
		repeat (12) @(posedge sys_clk);
		chk_reg(iae_pkg::ADR_PEND, 32'h0);
		r = $urandom;
		ce_pin <= ~r[0];
		ext_irq_pin <= r[5:1];
		periph_irq <= r[11:6];
		@(posedge sys_clk);
		periph_irq <= 6'h00;
		repeat (12) @(posedge sys_clk);
		chk_reg(iae_pkg::ADR_PEND, {20'h0, r[11:0]});
		wb(1'b1, iae_pkg::ADR_PEND, 32'hfff);
		wb(1'b1, iae_pkg::ADR_EDGE, 32'h7);
		chk_reg(iae_pkg::ADR_PEND, {28'h0, ~r[3:1], 1'b0});
		wb(1'b1, iae_pkg::ADR_EDGE, 32'h0);
		periph_irq <= 6'h3f;
		@(posedge sys_clk);
		periph_irq <= 6'h00;
		exp_pend = 32'hfce;
		chk_reg(iae_pkg::ADR_PEND, exp_pend);
		exp_enab = $urandom & 32'hfff;
		wb(1'b1, iae_pkg::ADR_ENAB, exp_enab);
		chk_reg(iae_pkg::ADR_ENAB, exp_enab);
		repeat (5) begin
			idx = -1;
			for (int j = 11; j >= 0; j--)
				if (exp_pend[j] && exp_enab[j])
					idx = j;
			cpu(5'h08);
			cpu(5'h10);
			cpu(5'h01);
			for (i = 0; i < 40 && irq_cycle !== 1'b1; i++)
				@(posedge sys_clk);
			chk("taken", idx >= 0, irq_cycle);
			if (idx >= 0) begin
				chk("vector", {1'b1, iae_pkg::VEC_TOP - 14'(idx)}, {pc_load, pc_value});
				pc_saved = pc_next;
				exp_pend[idx] = 1'b0;
				for (i = 0; i < 100 && irq_cycle === 1'b1; i++)
					@(posedge sys_clk);
				chk("cycles", iae_pkg::INSTR_CYC, i);
				if (i >= 100) print_verdict();
				chk_reg(iae_pkg::ADR_STAT, 32'h710);
				chk_reg(iae_pkg::ADR_PEND, exp_pend);
				cpu(idx[0] ? 5'h02 : 5'h04);
				@(posedge sys_clk);
				chk("return", {1'b1, pc_saved}, {pc_load, pc_value});
				chk_reg(iae_pkg::ADR_STAT, 32'h0);
			end
		end
		print_verdict();
	end
endmodule // iae_irq_accept_bench
